/* File: include/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

  // Byte addresses of the registers on the AXI4-Lite bus.
  localparam logic [31:0] ADDR_CONTROL = 32'h0000_0000;
  localparam logic [31:0] ADDR_KEY = 32'h0000_0004;
  localparam logic [31:0] ADDR_PAGE = 32'h0000_0008;
  localparam logic [31:0] ADDR_OFFSET = 32'h0000_000C;
  localparam logic [31:0] ADDR_LATCH_LO = 32'h0000_0010;
  localparam logic [31:0] ADDR_LATCH_HI = 32'h0000_0014;

  // Register selector codes returned by the address decoder.
  typedef enum logic [2:0] {
    SEL_NONE, SEL_CONTROL, SEL_KEY, SEL_PAGE, SEL_OFFSET, SEL_LATCH_LO, SEL_LATCH_HI
  } reg_sel_t;

  // Bit positions inside the control register.
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_ENABLE_BIT = 14;
  localparam int CTRL_ERROR_BIT = 13;
  localparam int CTRL_ERASE_BIT = 6;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 4;

  // Unlock key values, written in this order.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Operation codes.
  localparam logic [3:0] OP_BULK_ERASE = 4'hF;
  localparam logic [3:0] OP_WORD_PROG = 4'h3;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h2;
  localparam logic [3:0] OP_ROW_PROG = 4'h1;

  // Operation kinds presented to the flash array.
  typedef enum logic [1:0] {KIND_ROW, KIND_WORD, KIND_BLOCK, KIND_BULK} op_kind_t;

  // Array geometry: rows of 64 words, erase blocks of 8 rows or 512 words.
  localparam int ROW_WORDS = 64;
  localparam int BLOCK_ROWS = 8;
  localparam int BLOCK_WORDS = ROW_WORDS * BLOCK_ROWS;
  localparam int WORD_W = 24;
  localparam int IDX_W = 6;
  localparam logic [5:0] LAST_IDX = 6'h3F;
  localparam int ROW_ALIGN_BITS = 7;
  localparam int BLOCK_ALIGN_BITS = 10;
  localparam logic [15:0] OFFSET_STEP = 16'h0002;

  // Reset values.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [23:0] LATCH_RESET = 24'hFFFFFF;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : flash_ctrl_pkg

/* File: logic/unlock_key_tracker.sv */
`timescale 1ns/1ps
module unlock_key_tracker import flash_ctrl_pkg::*; (
  // Clock, power-on reset and warm reset.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic warm_reset,
  // One pulse per completed register write, and whether it hit the key register.
  input wire logic wr_fire,
  input wire logic key_sel,
  input wire logic [7:0] key_data,
  // High while the next register write may launch an operation.
  output logic armed_q
);

  typedef struct packed {
    logic first_ok;
    logic armed;
  } key_state_t;

  key_state_t s_q, s_d;

  // Any write that is not the expected next key drops the sequence, so the
  // unlock is only good for the write that follows it directly.
  always_comb begin
    s_d = s_q;
    if (wr_fire) begin
      s_d.first_ok = 1'b0;
      s_d.armed = 1'b0;
      if (key_sel && key_data == KEY_FIRST) begin
        s_d.first_ok = 1'b1;
      end else if (key_sel && key_data == KEY_SECOND && s_q.first_ok) begin
        s_d.armed = 1'b1;
      end
    end
    if (warm_reset) begin
      s_d = '0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign armed_q = s_q.armed;

  // Arming always comes from a second key right after the first.
  arm_needs_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(armed_q) |-> $past(s_q.first_ok) && $past(key_data) == KEY_SECOND)
    else $error("Unlock armed without the key pair.");

  // An armed unlock never survives a second write.
  arm_one_shot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    armed_q && wr_fire |=> !armed_q)
    else $error("Unlock survived a following write.");

endmodule : unlock_key_tracker

/* File: logic/flash_program_erase_control.sv */
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - No program or erase runs unless unlocked immediately beforehand.
// - Setting control bit 15 launches the operation; hardware clears it when done.
// - Start bit is set-only; writing zero does nothing; zero means idle.
// - The processor is held stalled while an operation runs.
// - Write-enable bit 14 must be one, otherwise all operations are inhibited.
// - Error flag bit 13 sets on improper sequence or termination.
// - Erase-select bit 6 picks erase or program variant of the code.
// - Codes: 1111 bulk erase, 0011 word, 0010 block erase, 0001 row.
// - Any other operation code performs no flash operation.
// - Bulk erase is honoured only in serial programming mode.
// - Control bits return to zero only on power-on reset.
// - Erase granularity is an eight-row block of 512 words.
// - Latched write data reaches the array only when an operation starts.
module flash_program_erase_control import flash_ctrl_pkg::*; (
  // Clock and power-on reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Warm reset from other sources; it leaves the control bits alone.
  input wire logic warm_reset,
  // Serial programming mode indication.
  input wire logic serial_programming_mode,
  // AXI4-Lite write address and data.
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Flash array command port.
  output logic flash_op_valid_q,
  output logic [1:0] flash_op_kind_q,
  output logic [23:0] flash_op_addr_q,
  output logic flash_data_valid_q,
  output logic [5:0] flash_data_idx_q,
  output logic [23:0] flash_data_q,
  input wire logic flash_done,
  input wire logic flash_fail,
  // Processor stall request.
  output logic cpu_stall_q
);

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_ISSUE, ST_WAIT} seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic start;
    logic enable;
    logic error;
    logic erase;
    logic [3:0] op;
    op_kind_t kind;
    logic [7:0] page;
    logic [15:0] offset;
    logic [ROW_WORDS-1:0][WORD_W-1:0] latch;
    logic [5:0] cnt;
    logic aw_held;
    logic w_held;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic op_valid;
    logic [23:0] op_addr;
    logic data_valid;
    logic [5:0] data_idx;
    logic [23:0] data;
    logic stall;
  } state_t;

  state_t s_q, s_d;
  logic key_armed;
  logic wr_fire;
  reg_sel_t wr_sel;
  logic start_try;
  logic start_ok;
  logic launch;
  logic [15:0] ctrl_view;
  logic [31:0] ctrl_new;
  logic [2:0] op_dec;

  // Maps a byte address onto a register; the upper bits must be zero too.
  function automatic reg_sel_t decode_addr(input logic [31:0] a);
    unique case (a)
      ADDR_CONTROL: decode_addr = SEL_CONTROL;
      ADDR_KEY: decode_addr = SEL_KEY;
      ADDR_PAGE: decode_addr = SEL_PAGE;
      ADDR_OFFSET: decode_addr = SEL_OFFSET;
      ADDR_LATCH_LO: decode_addr = SEL_LATCH_LO;
      ADDR_LATCH_HI: decode_addr = SEL_LATCH_HI;
      default: decode_addr = SEL_NONE;
    endcase
  endfunction : decode_addr

  // Merges written bytes into an old value under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction : merge

  // Decodes code and erase-select into {valid, kind}; mismatches are no-ops.
  function automatic logic [2:0] decode_op(input logic [3:0] op, input logic erase,
                                           input logic serial);
    decode_op = {1'b0, KIND_ROW};
    unique case (op)
      OP_BULK_ERASE: if (erase && serial) decode_op = {1'b1, KIND_BULK};
      OP_WORD_PROG: if (!erase) decode_op = {1'b1, KIND_WORD};
      OP_BLOCK_ERASE: if (erase) decode_op = {1'b1, KIND_BLOCK};
      OP_ROW_PROG: if (!erase) decode_op = {1'b1, KIND_ROW};
      default: decode_op = {1'b0, KIND_ROW};
    endcase
  endfunction : decode_op

  // Unlock tracking sits in its own module so its window is easy to audit.
  unlock_key_tracker u_key (
    .aclk(aclk),
    .aresetn(aresetn),
    .warm_reset(warm_reset),
    .wr_fire(wr_fire),
    .key_sel(wr_sel == SEL_KEY),
    .key_data(s_q.wdata[7:0]),
    .armed_q(key_armed)
  );

  // A write completes once both halves are held and no response is pending.
  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign wr_sel = decode_addr(s_q.awaddr);
  assign ctrl_view = {s_q.start, s_q.enable, s_q.error, 6'h00, s_q.erase, 2'h0, s_q.op};
  assign ctrl_new = merge({16'h0000, ctrl_view}, s_q.wdata, s_q.wstrb);
  assign start_try = wr_fire && wr_sel == SEL_CONTROL && ctrl_new[CTRL_START_BIT]
                     && !s_q.start;
  assign start_ok = key_armed && ctrl_new[CTRL_ENABLE_BIT];
  assign op_dec = decode_op(ctrl_new[CTRL_OP_W-1:0], ctrl_new[CTRL_ERASE_BIT],
                            serial_programming_mode);
  // A code that decodes to no operation is accepted quietly and launches nothing.
  assign launch = start_try && start_ok && op_dec[2];

  // Next-state logic for the bus slave, the registers and the sequencer.
  always_comb begin
    logic [2:0] dec;
    logic [5:0] lidx;
    logic err_set;
    logic [31:0] off_new;
    dec = op_dec;
    off_new = merge({16'h0000, s_q.offset}, s_q.wdata, s_q.wstrb);
    lidx = s_q.offset[IDX_W:1];
    err_set = 1'b0;
    s_d = s_q;
    s_d.op_valid = 1'b0;
    s_d.data_valid = 1'b0;

    // Address and data are caught independently, in either order.
    if (awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register write effects.
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wr_sel)
        SEL_CONTROL: begin
          // Settings are frozen while an operation runs so its target cannot move.
          if (!s_q.start) begin
            s_d.enable = ctrl_new[CTRL_ENABLE_BIT];
            s_d.error = ctrl_new[CTRL_ERROR_BIT];
            s_d.erase = ctrl_new[CTRL_ERASE_BIT];
            s_d.op = ctrl_new[CTRL_OP_W-1:0];
          end
        end
        SEL_PAGE: s_d.page = ctrl_new_page(s_q.page, s_q.wdata, s_q.wstrb);
        SEL_OFFSET: s_d.offset = off_new[15:0];
        SEL_LATCH_LO: begin
          if (!s_q.start && s_q.wstrb[1:0] == 2'h3) begin
            s_d.latch[lidx][15:0] = s_q.wdata[15:0];
          end
        end
        SEL_LATCH_HI: begin
          // The high write finishes a word, so it steps the offset like a post-increment.
          if (!s_q.start && s_q.wstrb[0]) begin
            s_d.latch[lidx][23:16] = s_q.wdata[7:0];
            s_d.offset = 16'(s_q.offset + OFFSET_STEP);
          end
        end
        SEL_KEY, SEL_NONE: begin
        end
      endcase
    end

    // A start attempt without a valid unlock or with writes inhibited is an error.
    if (start_try && !start_ok) begin
      err_set = 1'b1;
    end
    if (launch) begin
      s_d.start = 1'b1;
      s_d.error = 1'b0;
      s_d.kind = op_kind_t'(dec[1:0]);
      s_d.cnt = (op_kind_t'(dec[1:0]) == KIND_WORD) ? lidx : 6'h00;
      unique case (op_kind_t'(dec[1:0]))
        KIND_ROW: s_d.op_addr = {s_q.page, s_q.offset[15:ROW_ALIGN_BITS], 7'h00};
        KIND_WORD: s_d.op_addr = {s_q.page, s_q.offset};
        KIND_BLOCK: s_d.op_addr = {s_q.page, s_q.offset[15:BLOCK_ALIGN_BITS], 10'h000};
        KIND_BULK: s_d.op_addr = 24'h000000;
      endcase
      s_d.state = (op_kind_t'(dec[1:0]) inside {KIND_ROW, KIND_WORD}) ? ST_LOAD : ST_ISSUE;
    end

    // Sequencer: stream latches, issue the command, then wait for completion.
    unique case (s_q.state)
      ST_IDLE: begin
      end
      ST_LOAD: begin
        s_d.data_valid = 1'b1;
        s_d.data_idx = s_q.cnt;
        s_d.data = s_q.latch[s_q.cnt];
        s_d.cnt = 6'(s_q.cnt + 6'h01);
        if (s_q.kind == KIND_WORD || s_q.cnt == LAST_IDX) begin
          s_d.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        s_d.op_valid = 1'b1;
        s_d.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (flash_done || flash_fail) begin
          s_d.start = 1'b0;
          s_d.state = ST_IDLE;
          s_d.latch = {ROW_WORDS{LATCH_RESET}};
        end
        if (flash_fail) begin
          err_set = 1'b1;
        end
      end
    endcase

    // A hardware set wins over a software clear in the same cycle.
    if (err_set) begin
      s_d.error = 1'b1;
    end
    s_d.stall = s_d.start;

    // Read channel: one response per address, answered the cycle after it is taken.
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (decode_addr(araddr))
        SEL_CONTROL: s_d.rdata = {16'h0000, ctrl_view};
        SEL_PAGE: s_d.rdata = {24'h000000, s_q.page};
        SEL_OFFSET: s_d.rdata = {16'h0000, s_q.offset};
        SEL_LATCH_LO: s_d.rdata = {16'h0000, s_q.latch[lidx][15:0]};
        SEL_LATCH_HI: s_d.rdata = {24'h000000, s_q.latch[lidx][23:16]};
        SEL_KEY: s_d.rdata = 32'h0000_0000;
        SEL_NONE: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;

    // Warm reset clears the pointer registers but never the control bits.
    if (warm_reset) begin
      s_d.page = PAGE_RESET;
      s_d.offset = OFFSET_RESET;
    end
  end

  // Page register keeps only its low byte.
  function automatic logic [7:0] ctrl_new_page(input logic [7:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    ctrl_new_page = strb[0] ? nw[7:0] : old;
  endfunction : ctrl_new_page

  // State register; only the power-on reset reaches the control bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.latch <= {ROW_WORDS{LATCH_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // Port drivers, all straight from the state register.
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign flash_op_valid_q = s_q.op_valid;
  assign flash_op_kind_q = s_q.kind;
  assign flash_op_addr_q = s_q.op_addr;
  assign flash_data_valid_q = s_q.data_valid;
  assign flash_data_idx_q = s_q.data_idx;
  assign flash_data_q = s_q.data;
  assign cpu_stall_q = s_q.stall;

  // An operation only starts from an armed unlock with writes enabled.
  start_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.start) |-> $past(key_armed) && s_q.enable)
    else $error("Operation started without unlock or enable.");

  // The stall stands exactly while the sequencer is busy with an operation.
  stall_tracks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_stall_q == (s_q.state != ST_IDLE))
    else $error("Stall does not match the busy state.");

  // Completion clears the start bit on the next edge.
  done_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.state == ST_WAIT && flash_done |=> !s_q.start && s_q.state == ST_IDLE)
    else $error("Start bit not cleared at completion.");

  // Writing zero to the start bit while busy does not stop the operation.
  start_set_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_sel == SEL_CONTROL && s_q.start && !flash_done && !flash_fail
    |=> s_q.start)
    else $error("Software cleared the start bit.");

  // A refused start raises the error flag and touches nothing.
  bad_start_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_try && !start_ok |=> s_q.error && !s_q.start ##1 !flash_op_valid_q)
    else $error("Refused start did not flag an error.");

  // Bulk erase is only issued in serial programming mode.
  bulk_serial_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.start) && s_q.kind == KIND_BULK |-> $past(serial_programming_mode))
    else $error("Bulk erase outside serial programming mode.");

  // A row program streams at least eight consecutive latch words.
  row_stream_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flash_data_valid_q) && s_q.kind == KIND_ROW |-> flash_data_valid_q [*8])
    else $error("Row stream broke early.");

  // Nothing reaches the array while no operation is active.
  idle_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_q.start |-> !flash_data_valid_q && !flash_op_valid_q)
    else $error("Array accessed while idle.");

  // Erase commands are block aligned.
  block_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flash_op_valid_q && flash_op_kind_q == KIND_BLOCK |-> flash_op_addr_q[9:0] == 10'h000)
    else $error("Block erase address not aligned.");

  // Main scenarios.
  row_prog_c: cover property (@(posedge aclk) disable iff (!aresetn)
    flash_op_valid_q && flash_op_kind_q == KIND_ROW);
  word_prog_c: cover property (@(posedge aclk) disable iff (!aresetn)
    flash_op_valid_q && flash_op_kind_q == KIND_WORD);
  block_erase_c: cover property (@(posedge aclk) disable iff (!aresetn)
    flash_op_valid_q && flash_op_kind_q == KIND_BLOCK);
  refused_start_c: cover property (@(posedge aclk) disable iff (!aresetn)
    start_try && !start_ok);

endmodule : flash_program_erase_control

/* File: dv/flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Command and latch data from the controller.
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic data_valid,
  // When high, the next operation ends in a termination.
  input wire logic fail_next,
  // Completion pulses back to the controller.
  output logic done,
  output logic fail,
  // Tallies for the bench.
  output int n_ops,
  output int n_words,
  output logic [1:0] last_kind
);
  localparam int BUSY_CYCLES = 20;
  int cnt;
  // An operation runs a fixed time and never ends early, so a stall that drops too soon shows.
  always_ff @(posedge aclk) begin
    done <= 1'b0;
    fail <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      n_ops <= 0;
      n_words <= 0;
      last_kind <= 2'h0;
    end else begin
      if (data_valid) n_words <= n_words + 1; // Latch words only count once streamed.
      if (op_valid) begin
        n_ops <= n_ops + 1;
        last_kind <= op_kind;
        cnt <= BUSY_CYCLES;
      end else if (cnt == 1) begin
        cnt <= 0;
        done <= !fail_next;
        fail <= fail_next;
      end else if (cnt > 1) cnt <= cnt - 1;
    end
  end
endmodule : flash_array_model

/* File: dv/flash_program_erase_control_test.sv */
`timescale 1ns/1ps
module flash_program_erase_control_test import flash_ctrl_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, warm_reset = 1'b0, serial_programming_mode = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, op_v, d_v, done, fail, stall, fail_next = 1'b0;
  logic [1:0] bresp, rresp, kind, last_kind;
  logic [5:0] idx;
  logic [23:0] op_addr, fdata;
  int n_ops, n_words, errors = 0, n_tests = 0, ops0, words0;
  logic [31:0] v;
  logic [1:0] r;
  logic [15:0] cfg [7] = '{16'h4001, 16'h4003, 16'h4042, 16'h404F, 16'h4041, 16'h4005, 16'h404F};
  int exp_ops [7] = '{1, 1, 1, 0, 0, 0, 1};
  int exp_words [7] = '{64, 1, 0, 0, 0, 0, 0};
  logic [1:0] exp_kind [7] = '{KIND_ROW, KIND_WORD, KIND_BLOCK, 2'h0, 2'h0, 2'h0, KIND_BULK};
  logic [23:0] exp_addr [7] = '{24'h120480, 24'h120488, 24'h120400, 24'h0, 24'h0, 24'h0, 24'h0};
  logic [23:0] got_word, got_addr;

  flash_program_erase_control u_dut (.aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
    .serial_programming_mode(serial_programming_mode), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .flash_op_valid_q(op_v), .flash_op_kind_q(kind), .flash_op_addr_q(op_addr),
    .flash_data_valid_q(d_v), .flash_data_idx_q(idx), .flash_data_q(fdata),
    .flash_done(done), .flash_fail(fail), .cpu_stall_q(stall));

  flash_array_model u_flash (.aclk(aclk), .aresetn(aresetn), .op_valid(op_v), .op_kind(kind),
    .data_valid(d_v), .fail_next(fail_next), .done(done), .fail(fail), .n_ops(n_ops),
    .n_words(n_words), .last_kind(last_kind));

  // Keeps the last command address and latch word 3 as the array saw them.
  always @(posedge aclk) begin
    if (op_v) got_addr <= op_addr;
    if (d_v && idx == 6'h03) got_word <= fdata;
  end

  // The clock runs at 10 MHz.
  initial begin
    forever #50 aclk = ~aclk;
  end

  // Prints the tallies and the verdict, then stops the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken, then the response.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    // One idle edge, so that the next call never raises bready in this same step.
    @(posedge aclk);
  endtask : wr

  // Read: the address stands until taken, then rready waits for the answer.
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    // One idle edge, so that the next call never raises rready in this same step.
    @(posedge aclk);
  endtask : rd

  // Set up, unlock with the two keys back to back, then set start.
  task automatic launch(input logic [15:0] c);
    wr(ADDR_CONTROL, {16'h0000, c}, r);
    wr(ADDR_KEY, {24'h0, KEY_FIRST}, r);
    wr(ADDR_KEY, {24'h0, KEY_SECOND}, r);
    wr(ADDR_CONTROL, {16'h0000, c | 16'h8000}, r);
    repeat (2) @(posedge aclk);
  endtask : launch

  // Polls the start bit until hardware clears it; the wait is bounded.
  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      rd(ADDR_CONTROL, v, r);
      if (v[CTRL_START_BIT] === 1'b0) break;
    end
  endtask : wait_idle

  // A start attempt that must be refused: flash untouched and the error flag set.
  task automatic refuse(input logic [7:0] k1, input logic [7:0] k2, input bit mid,
                        input logic [15:0] c);
    ops0 = n_ops;
    wr(ADDR_CONTROL, {16'h0000, c}, r);
    wr(ADDR_KEY, {24'h0, k1}, r);
    if (mid) wr(ADDR_PAGE, 32'h0, r);
    wr(ADDR_KEY, {24'h0, k2}, r);
    wr(ADDR_CONTROL, {16'h0000, c | 16'h8000}, r);
    rd(ADDR_CONTROL, v, r);
    chk(v, {16'h0000, c | 16'h2000});
    chk(n_ops, ops0);
  endtask : refuse

  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CONTROL, v, r);
    chk(v, {16'h0000, CONTROL_RESET});
    rd(ADDR_KEY, v, r);
    chk(v, 32'h0);
    rd(32'h0000_0040, v, r);
    chk({v[1:0], r}, {2'h0, RESP_SLVERR});
    wr(32'h0000_0040, 32'h0, r);
    chk(r, RESP_SLVERR);
    refuse(8'h00, 8'h00, 1'b0, 16'h4042);
    refuse(KEY_FIRST, KEY_SECOND, 1'b1, 16'h4042);
    refuse(KEY_FIRST, 8'h12, 1'b0, 16'h4042);
    refuse(KEY_FIRST, KEY_SECOND, 1'b0, 16'h0042);
    for (int i = 0; i < 7; i++) begin
      serial_programming_mode <= (i == 6);
      ops0 = n_ops;
      words0 = n_words;
      if (i == 0) begin
        wr(ADDR_PAGE, 32'h0000_0012, r);
        wr(ADDR_OFFSET, 32'h0000_0486, r);
        wr(ADDR_LATCH_LO, 32'h0000_1234, r);
        wr(ADDR_LATCH_HI, 32'h0000_0056, r);
      end
      launch(cfg[i]);
      if (exp_ops[i] == 1) begin
        chk(stall, 1'b1);
        rd(ADDR_CONTROL, v, r);
        chk(v[CTRL_START_BIT], 1'b1);
        wr(ADDR_CONTROL, {16'h0000, cfg[i]}, r);
        rd(ADDR_CONTROL, v, r);
        chk(v[CTRL_START_BIT], 1'b1);
      end
      wait_idle();
      chk(v, {16'h0000, cfg[i]});
      chk(stall, 1'b0);
      chk(n_ops - ops0, exp_ops[i]);
      chk(n_words - words0, exp_words[i]);
      if (exp_ops[i] == 1) chk(last_kind, exp_kind[i]);
      if (exp_ops[i] == 1) chk(got_addr, exp_addr[i]);
      if (i == 0) chk(got_word, 24'h561234);
    end
    serial_programming_mode <= 1'b0;
    fail_next <= 1'b1;
    launch(16'h4042);
    wait_idle();
    chk(v, 32'h0000_6042);
    fail_next <= 1'b0;
    wr(ADDR_CONTROL, 32'h0000_4042, r);
    warm_reset <= 1'b1;
    @(posedge aclk);
    warm_reset <= 1'b0;
    rd(ADDR_CONTROL, v, r);
    chk(v, 32'h0000_4042);
    complete_run();
  end

  // The tests need well under 1,000 cycles; a hang is cut off well beyond that.
  initial begin
    #6000000;
    errors++;
    complete_run();
  end
endmodule : flash_program_erase_control_test
